//--- include/txp_params.svh
// Constants for the transmit policy block: register map, field layout, defaults
`ifndef TXP_PARAMS_SVH
`define TXP_PARAMS_SVH
// ===========================================================
// Register byte offsets
`define TXP_OFS_CTRL      8'h00
`define TXP_OFS_MCAST     8'h04
`define TXP_OFS_MAXMOD    8'h08
`define TXP_OFS_SNRFAC    8'h0C
`define TXP_OFS_RETRY     8'h10
`define TXP_OFS_BURSTINT  8'h14
`define TXP_OFS_STATUS    8'h18
`define TXP_OFS_SNRAVG    8'h1C
// ===========================================================
// Control register bit positions
`define TXP_CTRL_ADAPT    0
`define TXP_CTRL_PRIO     1
`define TXP_CTRL_BURST    2
`define TXP_CTRL_DFS      3
`define TXP_CTRL_WEP      4
// Status register bit positions
`define TXP_ST_BURST      0
`define TXP_ST_REFUSED    1
// ===========================================================
// Ranges and defaults
`define TXP_LVL_MIN       4'h1
`define TXP_LVL_TOP       4'h8
`define TXP_LVL_TOP_REVA  4'h7
`define TXP_LVL_VAR_F     4'h5
`define TXP_FAC_MIN       6'h3F
`define TXP_FAC_MAX       6'h20
`define TXP_FAC_DEF       6'h05
`define TXP_RETRY_MIN     4'h1
`define TXP_RETRY_MAX     4'hE
`define TXP_RETRY_DEF     4'hA
`define TXP_BURST_DEF_MS  16'h0005
`define TXP_BURST_MIN_MS  16'h0001
`define TXP_CTRL_RST      5'h04
// Hardware revision codes on the strap input
`define TXP_REV_A         4'h0
`define TXP_REV_B         4'h1
`define TXP_REV_F         4'h5
`endif

//--- include/txp_pkg.sv
// Types shared by the transmit policy block
package txp_pkg;
   typedef enum logic [1:0] {
      TXP_FR_UNICAST,
      TXP_FR_GROUP,
      TXP_FR_MGMT,
      TXP_FR_RSVD
   } txp_frame_e;
   typedef enum logic [1:0] {
      TXP_ST_IDLE,
      TXP_ST_BUSY
   } txp_state_e;
   typedef logic [3:0] txp_level_t;
endpackage

//--- rtl/txp_policy.sv
// Transmit modulation, retry and burst policy with an APB register file
`timescale 1ns/1ps
`include "txp_params.svh"

// Behaviour
// - Group data frames use multicast level and are never retransmitted.
// - Management and control frames use the sub-band's lowest level.
// - Level settings accept 1..8; revision A tops out at 7.
// - Multicast level resets to 1.
// - Adaptive off: unicast uses the maximum level setting as fixed level.
// - Adaptive on: chosen unicast level is capped by maximum level setting.
// - Maximum level defaults 8, revision A 7, revision F subscriber 5.
// - SNR average with memory factor -1..32, default 5; -1 means latest sample.
// - Retransmit unicast up to retry count; drop when reached, adaptive off.
// - Retry count accepts 1..14, defaults to 10.
// - Retry count ignored while link prioritisation is on.
// - Burst only for unicast data, never group frames.
// - Burst only when the sub-band supports it.
// - Revision B or earlier base unit refuses burst enable while DYNAMIC_FREQUENCY_SELECTION on.
// - Revision B or earlier unit refuses burst enable while WEP on.
// - All burst settings ignored while link prioritisation is on.
// - Burst on/off setting gates bursts and resets enabled.
// - Burst interval 1..sub-band maximum, default min of 5 ms and maximum.
module txp_policy
   import txp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [3:0]  hw_rev,
   input  wire logic        base_station_unit,
   input  wire logic        variant_f,
   input  wire logic [3:0]  band_min_level,
   input  wire logic        band_burst_ok,
   input  wire logic [15:0] band_max_burst_ms,
   input  wire logic        frame_start,
   input  wire logic [1:0]  frame_kind,
   input  wire logic [3:0]  adapt_level,
   input  wire logic        tx_ack,
   input  wire logic        tx_fail,
   input  wire logic        snr_valid,
   input  wire logic [7:0]  snr_in,
   output logic      [3:0]  tx_level,
   output logic             tx_burst,
   output logic      [15:0] tx_burst_ms,
   output logic             tx_retry,
   output logic             tx_drop,
   output logic             tx_busy
);
   // ===========================================================
   // Registers
   logic             init_q;
   logic [3:0]       rev_q;
   logic             base_q;
   logic             varf_q;
   logic [4:0]       ctrl_q;
   txp_level_t       mcast_q;
   txp_level_t       maxmod_q;
   logic [5:0]       fac_q;
   logic [3:0]       retry_q;
   logic [15:0]      bint_q;
   logic             refused_q;
   logic [7:0]       avg_q;
   txp_state_e       st_q;
   txp_frame_e       kind_q;
   logic [3:0]       rcnt_q;
   logic [3:0]       rlim_q;
   logic             ren_q;
   logic             adapt_q;
   logic             wr;
   logic             rd_ok;
   logic             wr_ok;
   logic             old_rev;
   txp_level_t       top;
   txp_level_t       wlvl;
   logic [5:0]       wfac;
   logic [3:0]       wret;
   logic [15:0]      wbi;
   logic             bad_en;
   logic [4:0]       ctrl_d;
   txp_frame_e       kind_in;

   assign kind_in = txp_frame_e'(frame_kind);
   assign wr      = psel & penable & pwrite;
   assign old_rev = (rev_q <= `TXP_REV_B);
   assign top     = (rev_q == `TXP_REV_A) ? `TXP_LVL_TOP_REVA : `TXP_LVL_TOP;
   assign wlvl    = pwdata[3:0];
   assign wfac    = pwdata[5:0];
   assign wret    = pwdata[3:0];
   assign wbi     = pwdata[15:0];

   // ===========================================================
   // APB decode; pready is always high, bad address or value flags pslverr
   always_comb begin
      wr_ok = 1'b1;
      case (paddr)
         `TXP_OFS_CTRL:     wr_ok = 1'b1;
         `TXP_OFS_MCAST,
         `TXP_OFS_MAXMOD:   wr_ok = (pwdata[31:4] == 28'h0000000) &&
                                    (wlvl >= `TXP_LVL_MIN) && (wlvl <= top);
         `TXP_OFS_SNRFAC:   wr_ok = (pwdata[31:6] == 26'h0000000) &&
                                    ((wfac <= `TXP_FAC_MAX) || (wfac == `TXP_FAC_MIN));
         `TXP_OFS_RETRY:    wr_ok = (pwdata[31:4] == 28'h0000000) &&
                                    (wret >= `TXP_RETRY_MIN) && (wret <= `TXP_RETRY_MAX);
         `TXP_OFS_BURSTINT: wr_ok = (pwdata[31:16] == 16'h0000) &&
                                    (wbi >= `TXP_BURST_MIN_MS) && (wbi <= band_max_burst_ms);
         `TXP_OFS_STATUS:   wr_ok = 1'b1;
         default:           wr_ok = 1'b0;
      endcase
   end

   always_comb begin
      rd_ok  = 1'b1;
      prdata = 32'h00000000;
      case (paddr)
         `TXP_OFS_CTRL:     prdata = {27'h0000000, ctrl_q};
         `TXP_OFS_MCAST:    prdata = {28'h0000000, mcast_q};
         `TXP_OFS_MAXMOD:   prdata = {28'h0000000, maxmod_q};
         `TXP_OFS_SNRFAC:   prdata = {26'h0000000, fac_q};
         `TXP_OFS_RETRY:    prdata = {28'h0000000, retry_q};
         `TXP_OFS_BURSTINT: prdata = {16'h0000, bint_q};
         `TXP_OFS_STATUS:   prdata = {30'h00000000, refused_q, ctrl_q[`TXP_CTRL_BURST] &
                                      band_burst_ok & ~ctrl_q[`TXP_CTRL_PRIO]};
         `TXP_OFS_SNRAVG:   prdata = {24'h000000, avg_q};
         default:           rd_ok  = 1'b0;
      endcase
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & (pwrite ? ~wr_ok : ~rd_ok);

   // ===========================================================
   // Straps are caught on the first edge after reset release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         init_q <= 1'b1;
         rev_q  <= `TXP_REV_B;
         base_q <= 1'b0;
         varf_q <= 1'b0;
      end else if (init_q) begin
         init_q <= 1'b0;
         rev_q  <= hw_rev;
         base_q <= base_station_unit;
         varf_q <= variant_f;
      end
   end

   // ===========================================================
   // Control register; burst enable refused on old revisions with WEP, or with DYNAMIC_FREQUENCY_SELECTION on a base unit
   always_comb begin
      ctrl_d = pwdata[4:0];
      bad_en = 1'b0;
      // Checked on every write, so on old revisions burst never sits on next to WEP, nor next to DYNAMIC_FREQUENCY_SELECTION on a base unit
      if (pwdata[`TXP_CTRL_BURST] && old_rev &&
          ((base_q && pwdata[`TXP_CTRL_DFS]) || pwdata[`TXP_CTRL_WEP])) begin
         bad_en                 = 1'b1;
         ctrl_d[`TXP_CTRL_BURST] = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `TXP_CTRL_RST; // Burst option on, all else off
      end else if (init_q) begin
         ctrl_q <= `TXP_CTRL_RST;
      end else if (wr && paddr == `TXP_OFS_CTRL) begin
         ctrl_q <= ctrl_d;
      end
   end

   // Sticky refusal flag: a new refusal wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         refused_q <= 1'b0;
      end else if (wr && !init_q && paddr == `TXP_OFS_CTRL && bad_en) begin
         refused_q <= 1'b1;
      end else if (wr && paddr == `TXP_OFS_STATUS && pwdata[`TXP_ST_REFUSED]) begin
         refused_q <= 1'b0;
      end
   end

   // ===========================================================
   // Level, factor, retry and interval settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mcast_q  <= `TXP_LVL_MIN;
         maxmod_q <= `TXP_LVL_TOP;
         fac_q    <= `TXP_FAC_DEF;
         retry_q  <= `TXP_RETRY_DEF;
         bint_q   <= `TXP_BURST_DEF_MS;
      end else if (init_q) begin
         // Defaults that depend on straps or band load once after release
         if (!base_station_unit && variant_f && hw_rev == `TXP_REV_F) begin
            maxmod_q <= `TXP_LVL_VAR_F;
         end else if (hw_rev == `TXP_REV_A) begin
            maxmod_q <= `TXP_LVL_TOP_REVA;
         end else begin
            maxmod_q <= `TXP_LVL_TOP;
         end
         bint_q <= (band_max_burst_ms < `TXP_BURST_DEF_MS) ?
                   band_max_burst_ms : `TXP_BURST_DEF_MS;
      end else if (wr && wr_ok) begin
         case (paddr)
            `TXP_OFS_MCAST:    mcast_q  <= wlvl;
            `TXP_OFS_MAXMOD:   maxmod_q <= wlvl;
            `TXP_OFS_SNRFAC:   fac_q    <= wfac;
            `TXP_OFS_RETRY:    retry_q  <= wret;
            `TXP_OFS_BURSTINT: bint_q   <= wbi;
            default:           ;
         endcase
      end
   end

   // ===========================================================
   // SNR average: (avg*f + meas)/(f+1); factor -1 passes the sample through
   logic [13:0] snr_num;
   logic [13:0] snr_q14;
   always_comb begin
      snr_num = 14'(avg_q * fac_q) + 14'(snr_in);
      snr_q14 = snr_num / 14'(fac_q + 6'h01);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avg_q <= 8'h00;
      end else if (snr_valid) begin
         avg_q <= (fac_q == `TXP_FAC_MIN) ? snr_in : snr_q14[7:0];
      end
   end

   // ===========================================================
   // Frame path: everything is sampled at frame start
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q        <= TXP_ST_IDLE;
         kind_q      <= TXP_FR_MGMT;
         tx_level    <= `TXP_LVL_MIN;
         tx_burst    <= 1'b0;
         tx_burst_ms <= `TXP_BURST_DEF_MS;
         rlim_q      <= `TXP_RETRY_DEF;
         ren_q       <= 1'b0;
         adapt_q     <= 1'b0;
      end else begin
         case (st_q)
            TXP_ST_IDLE: begin
               if (frame_start && !init_q) begin
                  st_q    <= TXP_ST_BUSY;
                  kind_q  <= kind_in;
                  adapt_q <= ctrl_q[`TXP_CTRL_ADAPT];
                  rlim_q  <= retry_q;
                  // Retry limit applies only to unicast and not under prioritisation
                  ren_q   <= (kind_in == TXP_FR_UNICAST) && !ctrl_q[`TXP_CTRL_PRIO];
                  case (kind_in)
                     TXP_FR_UNICAST: begin
                        if (ctrl_q[`TXP_CTRL_ADAPT] && adapt_level < maxmod_q) begin
                           tx_level <= (adapt_level < `TXP_LVL_MIN) ? `TXP_LVL_MIN
                                                                    : adapt_level;
                        end else begin
                           tx_level <= maxmod_q;
                        end
                     end
                     TXP_FR_GROUP: tx_level <= mcast_q;
                     default:      tx_level <= band_min_level;
                  endcase
                  tx_burst <= (kind_in == TXP_FR_UNICAST) && ctrl_q[`TXP_CTRL_BURST] &&
                              band_burst_ok && !ctrl_q[`TXP_CTRL_PRIO];
                  tx_burst_ms <= (bint_q > band_max_burst_ms) ? band_max_burst_ms
                                                               : bint_q;
               end
            end
            TXP_ST_BUSY: begin
               if (tx_ack || tx_drop || (tx_fail && !tx_retry)) begin
                  st_q     <= TXP_ST_IDLE;
                  tx_burst <= 1'b0;
               end
            end
            default: st_q <= TXP_ST_IDLE;
         endcase
      end
   end

   // ===========================================================
   // Retry counting; group and management frames end on first failure
   logic can_retry;
   assign can_retry = ren_q && (rcnt_q < rlim_q);
   assign tx_busy   = (st_q == TXP_ST_BUSY);
   assign tx_retry  = tx_busy && tx_fail && (can_retry || (kind_q == TXP_FR_UNICAST &&
                      (adapt_q || !ren_q)));
   assign tx_drop   = tx_busy && tx_fail && ren_q && !can_retry && !adapt_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rcnt_q <= 4'h0;
      end else if (!tx_busy) begin
         rcnt_q <= 4'h0;
      end else if (tx_retry && can_retry) begin
         rcnt_q <= rcnt_q + 4'h1;
      end
   end

   // ===========================================================
   // Checks; frame-start checks look back at what the start edge saw
   logic start_ok;
   assign start_ok = (st_q == TXP_ST_IDLE) && frame_start && !init_q;

   chk_group_no_retry: assert property (@(posedge clk) disable iff (rst)
      (tx_busy && kind_q == TXP_FR_GROUP) |-> !tx_retry)
      else $error("group frame retransmitted");
   chk_mcast_level: assert property (@(posedge clk) disable iff (rst)
      (start_ok && kind_in == TXP_FR_GROUP) |=> tx_level == $past(mcast_q))
      else $error("group frame not at multicast level");
   chk_mgmt_level: assert property (@(posedge clk) disable iff (rst)
      (start_ok && kind_in == TXP_FR_MGMT) |=> tx_level == $past(band_min_level))
      else $error("management frame not at band minimum level");
   chk_level_range: assert property (@(posedge clk) disable iff (rst)
      !init_q |-> (mcast_q >= `TXP_LVL_MIN && mcast_q <= top &&
                   maxmod_q >= `TXP_LVL_MIN && maxmod_q <= top))
      else $error("level setting out of range");
   chk_fixed_level: assert property (@(posedge clk) disable iff (rst)
      (start_ok && kind_in == TXP_FR_UNICAST && !ctrl_q[`TXP_CTRL_ADAPT])
      |=> tx_level == $past(maxmod_q))
      else $error("fixed unicast level differs from maximum");
   chk_adapt_cap: assert property (@(posedge clk) disable iff (rst)
      (start_ok && kind_in == TXP_FR_UNICAST && ctrl_q[`TXP_CTRL_ADAPT])
      |=> (tx_level <= $past(maxmod_q) && tx_level >= `TXP_LVL_MIN))
      else $error("adaptive unicast level outside cap");
   chk_retry_cap: assert property (@(posedge clk) disable iff (rst)
      (tx_busy && ren_q) |-> rcnt_q <= rlim_q)
      else $error("retries beyond limit");
   chk_drop_at_limit: assert property (@(posedge clk) disable iff (rst)
      tx_drop |-> (rcnt_q == rlim_q && !adapt_q) ##1 !tx_busy)
      else $error("drop without reaching limit");
   chk_group_no_drop: assert property (@(posedge clk) disable iff (rst)
      (tx_busy && kind_q != TXP_FR_UNICAST) |-> !tx_drop)
      else $error("group or management frame dropped");
   chk_prio_retry: assert property (@(posedge clk) disable iff (rst)
      (tx_busy && kind_q == TXP_FR_UNICAST && !ren_q && tx_fail) |-> (tx_retry && !tx_drop))
      else $error("retry limit applied under prioritisation");
   chk_burst_gate: assert property (@(posedge clk) disable iff (rst)
      tx_burst |-> (kind_q == TXP_FR_UNICAST && tx_busy))
      else $error("burst on non-unicast frame");
   chk_burst_band: assert property (@(posedge clk) disable iff (rst)
      (start_ok && !band_burst_ok) |=> !tx_burst)
      else $error("burst on a band without burst support");
   chk_burst_refuse: assert property (@(posedge clk) disable iff (rst)
      (wr && !init_q && paddr == `TXP_OFS_CTRL && bad_en)
      |=> !ctrl_q[`TXP_CTRL_BURST] && refused_q)
      else $error("burst enable not refused");
   chk_prio_burst: assert property (@(posedge clk) disable iff (rst)
      (start_ok && ctrl_q[`TXP_CTRL_PRIO]) |=> !tx_burst [*2])
      else $error("burst under prioritisation");
   chk_burst_opt: assert property (@(posedge clk) disable iff (rst)
      (start_ok && !ctrl_q[`TXP_CTRL_BURST]) |=> !tx_burst)
      else $error("burst with burst option off");
   chk_burst_ms_cap: assert property (@(posedge clk) disable iff (rst)
      start_ok |=> tx_burst_ms <= $past(band_max_burst_ms))
      else $error("burst interval above band maximum");
   chk_snr_pass: assert property (@(posedge clk) disable iff (rst)
      (snr_valid && fac_q == `TXP_FAC_MIN) |=> avg_q == $past(snr_in))
      else $error("factor minus one did not pass the sample through");
   chk_factor_range: assert property (@(posedge clk) disable iff (rst)
      (fac_q <= `TXP_FAC_MAX || fac_q == `TXP_FAC_MIN))
      else $error("memory factor out of range");
   chk_retry_range: assert property (@(posedge clk) disable iff (rst)
      (retry_q >= `TXP_RETRY_MIN && retry_q <= `TXP_RETRY_MAX))
      else $error("retry count out of range");
   chk_hold_frame: assert property (@(posedge clk) disable iff (rst)
      (tx_busy && $past(tx_busy)) |-> $stable(tx_level) && $stable(tx_burst_ms))
      else $error("frame settings changed mid frame");
endmodule

//--- verification/txp_peer.sv
// Peer radio model: answers each transmit attempt with an ack or a failure
`timescale 1ns/1ps
module txp_peer (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tx_busy,
   input  wire logic       fail_mode,
   input  wire logic [3:0] delay,
   output logic            tx_ack,
   output logic            tx_fail
);
   logic [3:0] cnt_q;
   // ===========================================================
   // Answer one attempt after delay cycles; fail_mode alone picks failure or ack, whatever the frame kind
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q   <= 4'h0;
         tx_ack  <= 1'b0;
         tx_fail <= 1'b0;
      end else begin
         tx_ack  <= 1'b0;
         tx_fail <= 1'b0;
         // Re-arm after each answer so one pulse never spans two attempts
         if (!tx_busy || tx_ack || tx_fail) begin
            cnt_q <= 4'h0;
         end else if (cnt_q >= delay) begin
            cnt_q   <= 4'h0;
            tx_ack  <= !fail_mode;
            tx_fail <= fail_mode;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule

//--- verification/tb_txp_policy.sv
// Self-checking bench for the transmit policy block
`timescale 1ns/1ps
`include "txp_params.svh"
module tb_txp_policy
   import txp_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00, snr_in = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, tx_burst, tx_retry, tx_drop, tx_busy, tx_ack, tx_fail;
   logic [3:0]  hw_rev = 4'h2, band_min_level = 4'h2, adapt_level = 4'h1, tx_level;
   logic [3:0]  delay = 4'h0;
   logic        base_station_unit = 1'b1, variant_f = 1'b0, band_burst_ok = 1'b1;
   logic [15:0] band_max_burst_ms = 16'h0014, tx_burst_ms;
   logic        frame_start = 1'b0, snr_valid = 1'b0, fail_mode = 1'b0;
   logic [1:0]  frame_kind = 2'h0;
   int          num_errors = 0, checked = 0, cyc = 0, n_retry = 0, n_drop = 0;

   always #50 clk = ~clk;

   txp_policy i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .hw_rev, .base_station_unit, .variant_f, .band_min_level,
      .band_burst_ok, .band_max_burst_ms, .frame_start, .frame_kind, .adapt_level,
      .tx_ack, .tx_fail, .snr_valid, .snr_in, .tx_level, .tx_burst, .tx_burst_ms,
      .tx_retry, .tx_drop, .tx_busy);
   txp_peer i_peer (.clk, .rst, .tx_busy, .fail_mode, .delay, .tx_ack, .tx_fail);

   // ===========================================================
   // Closing report and timeout
   task automatic results();
      $display("checks=%0d errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (tx_retry === 1'b1) n_retry++;
      if (tx_drop === 1'b1) n_drop++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   // ===========================================================
   // Access tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Ends on the first edge that sees pready high; the bench timeout ends it otherwise
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk({30'h0, pready, pslverr}, {30'h0, 1'b1, e});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, exp);
   endtask

   task automatic reset_dut(input logic [3:0] rev, input logic base, input logic vf,
                            input logic [15:0] bmax);
      rst <= 1'b1;
      hw_rev <= rev;
      base_station_unit <= base;
      variant_f <= vf;
      band_max_burst_ms <= bmax;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // Starts a frame and checks what it was given once the start edge has landed
   task automatic frame(input logic [1:0] k, input logic [3:0] al, input logic [3:0] lvl,
                        input logic b);
      n_retry = 0;
      n_drop = 0;
      frame_start <= 1'b1;
      frame_kind <= k;
      adapt_level <= al;
      @(posedge clk);
      frame_start <= 1'b0;
      @(posedge clk);
      chk({26'h0, tx_busy, tx_burst, tx_level}, {26'h0, 1'b1, b, lvl});
   endtask

   task automatic fend(input int r, input int dr);
      int n;
      n = 0;
      while (tx_busy === 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      chk({31'h0, tx_busy}, 32'h0);
      if (r >= 0) chk(n_retry, r);
      chk(n_drop, dr);
   endtask

   task automatic snr(input logic [7:0] v);
      snr_valid <= 1'b1;
      snr_in <= v;
      @(posedge clk);
      snr_valid <= 1'b0;
      @(posedge clk);
   endtask

   // ===========================================================
   // Test sequence
   initial begin
      reset_dut(4'h2, 1'b1, 1'b0, 16'h0014);
      rdc(`TXP_OFS_CTRL, 32'h4);
      rdc(`TXP_OFS_MCAST, 32'h1);
      rdc(`TXP_OFS_MAXMOD, 32'h8);
      rdc(`TXP_OFS_SNRFAC, 32'h5);
      rdc(`TXP_OFS_RETRY, 32'hA);
      rdc(`TXP_OFS_BURSTINT, 32'h5);
      rdc(`TXP_OFS_STATUS, 32'h1);
      $display("test reset values done");
      apb(1'b1, `TXP_OFS_MCAST, 32'h9, 1'b1);
      apb(1'b1, `TXP_OFS_MCAST, 32'h0, 1'b1);
      apb(1'b1, `TXP_OFS_RETRY, 32'hF, 1'b1);
      apb(1'b1, `TXP_OFS_RETRY, 32'h0, 1'b1);
      apb(1'b1, `TXP_OFS_BURSTINT, 32'h15, 1'b1);
      apb(1'b1, `TXP_OFS_SNRFAC, 32'h21, 1'b1);
      apb(1'b0, 8'h20, 32'h0, 1'b1);
      chk(rd, 32'h0);
      apb(1'b1, `TXP_OFS_RETRY, 32'hE, 1'b0);
      rdc(`TXP_OFS_RETRY, 32'hE);
      apb(1'b1, `TXP_OFS_BURSTINT, 32'h14, 1'b0);
      rdc(`TXP_OFS_BURSTINT, 32'h14);
      $display("test ranges done");
      apb(1'b1, `TXP_OFS_MCAST, 32'h3, 1'b0);
      frame(TXP_FR_UNICAST, 4'h1, 4'h8, 1'b1);
      chk({16'h0, tx_burst_ms}, 32'h14);
      fend(0, 0);
      fail_mode <= 1'b1;
      frame(TXP_FR_GROUP, 4'h7, 4'h3, 1'b0);
      fend(0, 0);
      frame(TXP_FR_MGMT, 4'h7, 4'h2, 1'b0);
      fend(0, 0);
      fail_mode <= 1'b0;
      apb(1'b1, `TXP_OFS_CTRL, 32'h5, 1'b0);
      apb(1'b1, `TXP_OFS_MAXMOD, 32'h4, 1'b0);
      frame(TXP_FR_UNICAST, 4'h6, 4'h4, 1'b1);
      fend(0, 0);
      frame(TXP_FR_UNICAST, 4'h2, 4'h2, 1'b1);
      fend(0, 0);
      $display("test levels done");
      apb(1'b1, `TXP_OFS_CTRL, 32'h4, 1'b0);
      apb(1'b1, `TXP_OFS_RETRY, 32'h2, 1'b0);
      fail_mode <= 1'b1;
      frame(TXP_FR_UNICAST, 4'h6, 4'h4, 1'b1);
      fend(2, 1);
      apb(1'b1, `TXP_OFS_CTRL, 32'h6, 1'b0);
      frame(TXP_FR_UNICAST, 4'h6, 4'h4, 1'b0);
      repeat (40) @(posedge clk);
      fail_mode <= 1'b0;
      fend(-1, 0);
      chk({31'h0, n_retry > 2}, 32'h1);
      rdc(`TXP_OFS_STATUS, 32'h0);
      $display("test retry done");
      apb(1'b1, `TXP_OFS_CTRL, 32'h0, 1'b0);
      frame(TXP_FR_UNICAST, 4'h1, 4'h4, 1'b0);
      fend(0, 0);
      apb(1'b1, `TXP_OFS_CTRL, 32'h4, 1'b0);
      band_burst_ok <= 1'b0;
      frame(TXP_FR_UNICAST, 4'h1, 4'h4, 1'b0);
      fend(0, 0);
      rdc(`TXP_OFS_STATUS, 32'h0);
      band_burst_ok <= 1'b1;
      delay <= 4'h8;
      frame(TXP_FR_UNICAST, 4'h1, 4'h4, 1'b1);
      apb(1'b1, `TXP_OFS_MAXMOD, 32'h6, 1'b0);
      chk({28'h0, tx_level}, 32'h4);
      fend(0, 0);
      delay <= 4'h0;
      frame(TXP_FR_UNICAST, 4'h1, 4'h6, 1'b1);
      fend(0, 0);
      $display("test burst done");
      apb(1'b1, `TXP_OFS_SNRFAC, 32'h3F, 1'b0);
      snr(8'h28);
      rdc(`TXP_OFS_SNRAVG, 32'h28);
      apb(1'b1, `TXP_OFS_SNRFAC, 32'h1, 1'b0);
      snr(8'h14);
      rdc(`TXP_OFS_SNRAVG, 32'h1E);
      apb(1'b1, `TXP_OFS_CTRL, 32'h1C, 1'b0);
      rdc(`TXP_OFS_CTRL, 32'h1C);
      $display("test snr done");
      reset_dut(`TXP_REV_B, 1'b1, 1'b0, 16'h0014);
      apb(1'b1, `TXP_OFS_CTRL, 32'hC, 1'b0);
      rdc(`TXP_OFS_CTRL, 32'h8);
      rdc(`TXP_OFS_STATUS, 32'h2);
      apb(1'b1, `TXP_OFS_STATUS, 32'h2, 1'b0);
      rdc(`TXP_OFS_STATUS, 32'h0);
      apb(1'b1, `TXP_OFS_CTRL, 32'h14, 1'b0);
      rdc(`TXP_OFS_CTRL, 32'h10);
      rdc(`TXP_OFS_STATUS, 32'h2);
      reset_dut(`TXP_REV_A, 1'b1, 1'b0, 16'h0014);
      rdc(`TXP_OFS_MAXMOD, 32'h7);
      apb(1'b1, `TXP_OFS_MAXMOD, 32'h8, 1'b1);
      apb(1'b1, `TXP_OFS_MCAST, 32'h7, 1'b0);
      reset_dut(`TXP_REV_F, 1'b0, 1'b1, 16'h0003);
      rdc(`TXP_OFS_MAXMOD, 32'h5);
      rdc(`TXP_OFS_BURSTINT, 32'h3);
      apb(1'b1, `TXP_OFS_BURSTINT, 32'h4, 1'b1);
      $display("test revisions done");
      results();
   end
endmodule
